// [pkg/fsdt_defs.vh]
`ifndef FSDT_DEFS_VH
`define FSDT_DEFS_VH
// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define FSDT_OFF_CTRL     4'h0
`define FSDT_OFF_STAT     4'h4
`define FSDT_CTRL_RC_LSB  0
`define FSDT_STAT_TOP_LSB 0
`define FSDT_STAT_TAG_LSB 16
`define FSDT_RC_RST       2'h0
`define FSDT_TOP_RST      3'h0
`define FSDT_TAGW_RST     16'hffff
// ----------------------------------------------------------------------------
// Operations
// ----------------------------------------------------------------------------
`define FSDT_OP_LD_REAL   4'h0
`define FSDT_OP_ST_REAL   4'h1
`define FSDT_OP_ST_REALP  4'h2
`define FSDT_OP_XCHG      4'h3
`define FSDT_OP_LD_INT    4'h4
`define FSDT_OP_ST_INT    4'h5
`define FSDT_OP_ST_INTP   4'h6
`define FSDT_OP_LD_BCD    4'h7
`define FSDT_OP_ST_BCDP   4'h8
// ----------------------------------------------------------------------------
// Operand formats
// ----------------------------------------------------------------------------
`define FSDT_FMT_REG      3'h0
`define FSDT_FMT_SR       3'h1
`define FSDT_FMT_LR       3'h2
`define FSDT_FMT_TR       3'h3
`define FSDT_FMT_WI       3'h4
`define FSDT_FMT_SI       3'h5
`define FSDT_FMT_LI       3'h6
`define FSDT_FMT_BCD      3'h7
// ----------------------------------------------------------------------------
// Tags, rounding modes, exponent figures, sequence counts
// ----------------------------------------------------------------------------
`define FSDT_TAG_VALID    2'h0
`define FSDT_TAG_ZERO     2'h1
`define FSDT_TAG_SPECIAL  2'h2
`define FSDT_TAG_EMPTY    2'h3
`define FSDT_RC_NEAR      2'h0
`define FSDT_RC_DOWN      2'h1
`define FSDT_RC_UP        2'h2
`define FSDT_EXP_ALL1     15'h7fff
`define FSDT_SR_DIFF      15'h3f80
`define FSDT_LR_DIFF      15'h3c00
`define FSDT_INT_EXP      15'h403e
`define FSDT_HALF_EXP     15'h3ffe
`define FSDT_SR_SHIFT     6'h28
`define FSDT_LR_SHIFT     6'h0b
`define FSDT_BLD_LAST     7'h11
`define FSDT_BST_LAST     7'h3f
`endif

// [verification/fsdt_core_assertions.sv]
module fsdt_core_chk (
    input wire        sys_clk_i,
    input wire        rst_n_i,
    input wire        cmd_valid_i,
    input wire [3:0]  cmd_op_i,
    input wire [2:0]  cmd_fmt_i,
    input wire        cmd_ready_o,
    input wire        res_valid_o,
    input wire        res_err_o,
    input wire [79:0] res_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire       tk = cmd_valid_i && cmd_ready_o;
    wire [6:0] oc = {cmd_op_i, cmd_fmt_i};
    property p_err; res_err_o |-> res_valid_o; endproperty
    a_err: assert property (p_err) else $error("refusal without completion");
    property p_tr; tk && oc == {4'h1, 3'h3} |=> res_valid_o && res_err_o; endproperty
    a_tr: assert property (p_tr) else $error("temp real store accepted");
    property p_ldi; tk && cmd_op_i == 4'h4 && cmd_fmt_i inside {[3'h4:3'h6]}
        |=> res_valid_o && !res_err_o; endproperty
    a_ldi: assert property (p_ldi) else $error("integer load not done");
    property p_sti; tk && oc == {4'h5, 3'h6} |=> res_valid_o && res_err_o; endproperty
    a_sti: assert property (p_sti) else $error("long integer store accepted");
    property p_stip; tk && oc == {4'h6, 3'h6} |=> res_valid_o && !res_err_o; endproperty
    a_stip: assert property (p_stip) else $error("long popping store refused");
    property p_bld; tk && cmd_op_i == 4'h7 |-> ##19 res_valid_o; endproperty
    a_bld: assert property (p_bld) else $error("decimal load late");
    property p_bst; tk && cmd_op_i == 4'h8 |-> ##65 res_valid_o; endproperty
    a_bst: assert property (p_bst) else $error("decimal store late");
    property p_busy; tk && cmd_op_i == 4'h8 |=> !cmd_ready_o [*8]; endproperty
    a_busy: assert property (p_busy) else $error("ready during decimal store");
    property p_hold; tk && cmd_op_i == 4'h4 |=> $stable(res_data_o); endproperty
    a_hold: assert property (p_hold) else $error("load altered result");
    c_xchg: cover property (tk && cmd_op_i == 4'h3);
    c_bld: cover property (tk && cmd_op_i == 4'h7);
    c_pop: cover property (tk && oc == {4'h2, 3'h0});
endmodule // fsdt_core_chk

bind fsdt_core fsdt_core_chk fsdt_core_chk_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_fmt_i(cmd_fmt_i), .cmd_ready_o(cmd_ready_o),
    .res_valid_o(res_valid_o), .res_err_o(res_err_o), .res_data_o(res_data_o));

// [verification/fsdt_host_model.sv]
module fsdt_host_model (
    input  wire         sys_clk_i,
    input  wire         ready_i,
    output logic        valid_o,
    output logic [3:0]  op_o,
    output logic [2:0]  fmt_o,
    output logic [2:0]  reg_o,
    output logic        given_o,
    output logic [79:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        valid_o = 1'b0;
        {op_o, fmt_o, reg_o, given_o, data_o} = '0;
    end
    // Operand scrambled on release, so a stale value never looks valid
    task issue(input logic [3:0] op, input logic [2:0] fmt, input logic [2:0] rg,
               input logic gv, input logic [79:0] d);
        @(posedge sys_clk_i);
        valid_o <= 1'b1;
        op_o    <= op;
        fmt_o   <= fmt;
        reg_o   <= rg;
        given_o <= gv;
        data_o  <= d;
        do @(posedge sys_clk_i); while (ready_i !== 1'b1);
        valid_o <= 1'b0;
        data_o  <= ~d;
    endtask
endmodule // fsdt_host_model

// [verification/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i, rst_n_i, reg_wr_i, reg_rd_i, rd_seen;
    logic [3:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, r;
    logic [79:0] last;
    logic [80:0] q_res[$];
    logic [31:0] q_reg[$];
    wire         cmd_valid_i, cmd_reg_given_i, cmd_ready_o, res_valid_o, res_err_o;
    wire [3:0]   cmd_op_i;
    wire [2:0]   cmd_fmt_i, cmd_reg_i;
    wire [79:0]  cmd_data_i, res_data_o;
    wire [31:0]  reg_rdata_o;
    int          n_errors, checks_done, cyc;
    fsdt_core fsdt_core_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_fmt_i(cmd_fmt_i),
        .cmd_reg_i(cmd_reg_i), .cmd_reg_given_i(cmd_reg_given_i), .cmd_data_i(cmd_data_i),
        .cmd_ready_o(cmd_ready_o), .res_valid_o(res_valid_o), .res_err_o(res_err_o),
        .res_data_o(res_data_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    fsdt_host_model fsdt_host_model_inst (.sys_clk_i(sys_clk_i), .ready_i(cmd_ready_o),
        .valid_o(cmd_valid_i), .op_o(cmd_op_i), .fmt_o(cmd_fmt_i), .reg_o(cmd_reg_i),
        .given_o(cmd_reg_given_i), .data_o(cmd_data_i));
    task stop_test;
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [80:0] seen, input logic [80:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t %h %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // Two idle cycles first so the last completion has reached the status
    task rd(input logic [3:0] a, input logic [31:0] e);
        repeat (2) @(posedge sys_clk_i);
        {reg_rd_i, reg_addr_i} <= {1'b1, a};
        q_reg.push_back(e);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
    endtask
    task cmd(input logic [3:0] op, input logic [2:0] fmt, input logic [2:0] rg,
             input logic gv, input logic [79:0] d, input logic st, input logic [79:0] e);
        logic err;
        err = op > 4'h8 || (op == 4'h1 && fmt > 3'h2) || (op == 4'h5 && fmt > 3'h5);
        if (st && !err)
            last = e;
        q_res.push_back({err, last});
        fsdt_host_model_inst.issue(op, fmt, rg, gv, d);
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        if (res_valid_o === 1'b1)
            chk({res_err_o, res_data_o}, q_res.pop_front());
        if (rd_seen)
            chk({49'h0, reg_rdata_o}, {49'h0, q_reg.pop_front()});
        rd_seen <= reg_rd_i;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        {rst_n_i, reg_wr_i, reg_rd_i, rd_seen, reg_addr_i, reg_wdata_i} = '0;
        {last, cyc, n_errors, checks_done} = '0;
        void'($urandom(88547));
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rd(4'h4, 32'hffff_0000);
        rd(4'h8, 32'h0000_0000);
        cmd(4'h4, 3'h4, 3'h0, 1'b0, 80'h0, 1'b0, 80'h0);
        rd(4'h4, 32'h7fff_0007);
        cmd(4'h4, 3'h4, 3'h0, 1'b0, 80'h5, 1'b0, 80'h0);
        cmd(4'h5, 3'h4, 3'h0, 1'b0, 80'h0, 1'b1, 80'h5);
        cmd(4'h3, 3'h0, 3'h5, 1'b0, 80'h0, 1'b0, 80'h0);
        cmd(4'h6, 3'h6, 3'h0, 1'b0, 80'h0, 1'b1, 80'h0);
        cmd(4'h6, 3'h4, 3'h0, 1'b0, 80'h0, 1'b1, 80'h5);
        r = $urandom;
        cmd(4'h4, 3'h5, 3'h0, 1'b0, {48'h0, r}, 1'b0, 80'h0);
        cmd(4'h6, 3'h5, 3'h0, 1'b0, 80'h0, 1'b1, {48'h0, r});
        cmd(4'h0, 3'h1, 3'h0, 1'b0, 80'h3f80_0000, 1'b0, 80'h0);
        cmd(4'h1, 3'h2, 3'h0, 1'b0, 80'h0, 1'b1, 80'h3ff0_0000_0000_0000);
        cmd(4'h0, 3'h0, 3'h0, 1'b1, 80'h0, 1'b0, 80'h0);
        cmd(4'h2, 3'h3, 3'h0, 1'b0, 80'h0, 1'b1, 80'h3fff_8000_0000_0000_0000);
        cmd(4'h2, 3'h0, 3'h0, 1'b1, 80'h0, 1'b0, 80'h0);
        cmd(4'h0, 3'h1, 3'h0, 1'b0, 80'h4020_0000, 1'b0, 80'h0);
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, i);
            cmd(4'h5, 3'h4, 3'h0, 1'b0, 80'h0, 1'b1, (i == 2) ? 80'h3 : 80'h2);
        end
        cmd(4'h8, 3'h7, 3'h0, 1'b0, 80'h0, 1'b1, 80'h3);
        cmd(4'h7, 3'h7, 3'h0, 1'b0, {1'b1, 79'h0}, 1'b0, 80'h0);
        cmd(4'h5, 3'h4, 3'h0, 1'b0, 80'h0, 1'b1, 80'h0);
        cmd(4'h2, 3'h3, 3'h0, 1'b0, 80'h0, 1'b1, {1'b1, 79'h0});
        cmd(4'h1, 3'h3, 3'h0, 1'b0, 80'h0, 1'b0, 80'h0);
        cmd(4'h5, 3'h6, 3'h0, 1'b0, 80'h0, 1'b0, 80'h0);
        cmd(4'h9, 3'h0, 3'h0, 1'b0, 80'h0, 1'b0, 80'h0);
        cmd(4'h0, 3'h1, 3'h0, 1'b0, 80'h7f80_0000, 1'b0, 80'h0);
        rd(4'h4, 32'hbfff_0007);
        cmd(4'h1, 3'h0, 3'h2, 1'b1, 80'h0, 1'b0, 80'h0);
        cmd(4'h4, 3'h6, 3'h0, 1'b0, {16'h0, 64'hffff_ffff_ffff_ffff}, 1'b0, 80'h0);
        cmd(4'h3, 3'h0, 3'h3, 1'b1, 80'h0, 1'b0, 80'h0);
        for (int i = 0; i < 2; i++)
            cmd(4'h2, 3'h1, 3'h0, 1'b0, 80'h0, 1'b1, 80'h7f80_0000);
        cmd(4'h3, 3'h0, 3'h0, 1'b0, 80'h0, 1'b0, 80'h0);
        cmd(4'h6, 3'h6, 3'h0, 1'b0, 80'h0, 1'b1, {16'h0, 64'hffff_ffff_ffff_ffff});
        rd(4'h4, 32'hffff_0001);
        repeat (4) @(posedge sys_clk_i);
        stop_test();
    end
endmodule // tb_top

// [verilog/fsdt_core.v]
// Functional notes
// - All formats load to and store from temp real
// - Loads, pops, exchanges and register stores update the tag word; non-popping memory stores do not
// - Sources untouched; conversion in work registers
// - Real load decrements pointer, then copies source
// - Short/long real widened; register zero duplicates top
// - Real store rounds significand, rebiases exponent
// - Special top chops significand and exponent
// - Store-pop stores, tags top empty, increments
// - Temp real destination only for popping store
// - Popping store to register zero only pops
// - Exchange swaps top with register, default one
// - Integer load converts word/short/long and pushes
// - Integer load tags zero or valid
// - Integer store rounds per mode; word/short only
// - Negative zero stored as all zeros
// - Popping integer store allows long destination
// - Decimal load exact, keeps sign of zero
// - Decimal digits unchecked; A-F undefined
// - Decimal store converts, writes, then pops
// - Decimal store rounds half up, ignores mode
`include "fsdt_defs.vh"

module fsdt_core (
    input  wire        sys_clk_i,
    input  wire        rst_n_i,
    input  wire        cmd_valid_i,
    input  wire [3:0]  cmd_op_i,
    input  wire [2:0]  cmd_fmt_i,
    input  wire [2:0]  cmd_reg_i,
    input  wire        cmd_reg_given_i,
    input  wire [79:0] cmd_data_i,
    output wire        cmd_ready_o,
    output wire        res_valid_o,
    output wire        res_err_o,
    output wire [79:0] res_data_o,
    input  wire [3:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output wire [31:0] reg_rdata_o
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_BLD  = 2'h1;
    localparam [1:0] ST_BST  = 2'h2;

    reg [79:0]  stk_q [0:7];
    reg [15:0]  tagw_q;
    reg [2:0]   top_q;
    reg [1:0]   rc_q;
    reg [1:0]   st_q;
    reg [6:0]   cnt_q;
    reg [63:0]  bin_q;
    reg [71:0]  bcd_q;
    reg         sgn_q;
    reg         ready_q;
    reg         res_valid_q;
    reg         res_err_q;
    reg [79:0]  res_data_q;
    reg [31:0]  rdata_q;

    // ------------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------------
    function [2:0] phys;
        input [2:0] base;
        input [2:0] off;
        reg   [3:0] t;
        begin
            t    = {1'b0, base} + {1'b0, off};
            phys = t[2:0];
        end
    endfunction

    function [1:0] tag_of;
        input [79:0] v;
        begin
            if (v[78:64] == `FSDT_EXP_ALL1 || (v[78:64] == 15'h0 && v[63:0] != 64'h0))
                tag_of = `FSDT_TAG_SPECIAL;
            else if (v[78:0] == 79'h0)
                tag_of = `FSDT_TAG_ZERO;
            else
                tag_of = `FSDT_TAG_VALID;
        end
    endfunction

    function [5:0] lzc;
        input [63:0] x;
        integer      k;
        begin
            lzc = 6'h00;
            for (k = 0; k < 64; k = k + 1) begin
                if (x[k]) begin
                    lzc = 6'h3f - k[5:0];
                end
            end
        end
    endfunction

    // Integer part, guard bit, sticky bit of x shifted right by sh
    function [65:0] shr_split;
        input [63:0] x;
        input [5:0]  sh;
        reg   [63:0] mask;
        begin
            mask      = (64'h1 << sh) - 64'h1;
            shr_split = {x >> sh, |(x & (mask ^ (mask >> 1))), |(x & (mask >> 1))};
        end
    endfunction

    function round_inc;
        input [1:0] rc;
        input       s;
        input       lsb;
        input       g;
        input       st;
        begin
            case (rc)
                `FSDT_RC_NEAR: round_inc = g & (st | lsb);
                `FSDT_RC_DOWN: round_inc = s & (g | st);
                `FSDT_RC_UP:   round_inc = ~s & (g | st);
                default:       round_inc = 1'b0;
            endcase
        end
    endfunction

    // Exact: any 64-bit magnitude fits the 64-bit significand
    function [79:0] int_to_tr;
        input        s;
        input [63:0] m;
        reg   [5:0]  z;
        begin
            z = lzc(m);
            if (m == 64'h0)
                int_to_tr = {s, 79'h0};
            else
                int_to_tr = {s, `FSDT_INT_EXP - {9'h0, z}, m << z};
        end
    endfunction

    function [79:0] real_to_tr;
        input [2:0]  f;
        input [79:0] d;
        reg          s;
        reg          all1;
        reg   [10:0] e;
        reg   [63:0] fa;
        reg   [14:0] rb;
        reg   [5:0]  z;
        begin
            if (f == `FSDT_FMT_SR) begin
                s    = d[31];
                e    = {3'h0, d[30:23]};
                fa   = {1'b0, d[22:0], 40'h0};
                all1 = &d[30:23];
                rb   = `FSDT_SR_DIFF;
            end else begin
                s    = d[63];
                e    = d[62:52];
                fa   = {1'b0, d[51:0], 11'h0};
                all1 = &d[62:52];
                rb   = `FSDT_LR_DIFF;
            end
            z = lzc(fa);
            if (f == `FSDT_FMT_TR)
                real_to_tr = d;
            else if (e == 11'h0 && fa == 64'h0)
                real_to_tr = {s, 79'h0};
            else if (all1)
                real_to_tr = {s, `FSDT_EXP_ALL1, 1'b1, fa[62:0]};
            else if (e == 11'h0)
                real_to_tr = {s, rb + 15'h1 - {9'h0, z}, fa << z};
            else
                real_to_tr = {s, rb + {4'h0, e}, 1'b1, fa[62:0]};
        end
    endfunction

    function [63:0] st_real;
        input [2:0]  f;
        input [79:0] v;
        input [1:0]  rc;
        input        special;
        reg          sr;
        reg          cy;
        reg   [65:0] sp;
        reg   [63:0] m;
        reg   [14:0] ex;
        begin
            sr = (f == `FSDT_FMT_SR);
            sp = shr_split(v[63:0], sr ? `FSDT_SR_SHIFT : `FSDT_LR_SHIFT);
            m  = sp[65:2] + {63'h0, round_inc(rc, v[79], sp[2], sp[1], sp[0])};
            cy = sr ? m[24] : m[53];
            ex = v[78:64] - (sr ? `FSDT_SR_DIFF : `FSDT_LR_DIFF) + {14'h0, cy};
            // Chop keeps all-ones and all-zeros exponents recognisable
            if (special)
                st_real = sr ? {32'h0, v[79], v[78:71], v[62:40]}
                             : {v[79], v[78:68], v[62:11]};
            else if (v[78:0] == 79'h0)
                st_real = sr ? {32'h0, v[79], 31'h0} : {v[79], 63'h0};
            else if (sr)
                st_real = {32'h0, v[79], ex[7:0], cy ? 23'h0 : m[22:0]};
            else
                st_real = {v[79], ex[10:0], cy ? 52'h0 : m[51:0]};
        end
    endfunction

    function [65:0] int_split;
        input [79:0] v;
        reg   [14:0] d;
        begin
            d = `FSDT_INT_EXP - v[78:64];
            if (v[78:64] < `FSDT_HALF_EXP)
                int_split = {64'h0, 1'b0, |v[63:0]};
            else if (v[78:64] == `FSDT_HALF_EXP)
                int_split = {64'h0, v[63], |v[62:0]};
            else if (v[78:64] > `FSDT_INT_EXP)
                int_split = {v[63:0], 2'b00};
            else
                int_split = shr_split(v[63:0], d[5:0]);
        end
    endfunction

    function [71:0] bcd_adj;
        input [71:0] b;
        integer      k;
        begin
            bcd_adj = b;
            for (k = 0; k < 18; k = k + 1) begin
                if (b[4*k +: 4] > 4'h4) begin
                    bcd_adj[4*k +: 4] = b[4*k +: 4] + 4'h3;
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Operand selection and conversion work area
    // ------------------------------------------------------------------------
    wire [2:0]  reg_eff = cmd_reg_given_i ? cmd_reg_i : 3'h1;
    wire [2:0]  p_sel   = phys(top_q, reg_eff);
    wire [2:0]  p_dec   = phys(top_q, 3'h7);
    wire [2:0]  p_inc   = phys(top_q, 3'h1);
    wire [79:0] top_v   = stk_q[top_q];
    wire [79:0] sel_v   = stk_q[p_sel];
    wire [1:0]  top_tag = tagw_q[{top_q, 1'b0} +: 2];
    wire [1:0]  sel_tag = tagw_q[{p_sel, 1'b0} +: 2];

    reg [63:0]  sx;
    reg [63:0]  mag;
    reg [79:0]  ld_int_v;
    reg [79:0]  ld_real_v;
    reg [79:0]  st_real_d;
    reg [65:0]  isp;
    reg [63:0]  irnd;
    reg [63:0]  isgn;
    reg [79:0]  st_int_d;
    reg [63:0]  bcd_mag;
    reg [63:0]  bld_next;
    reg [135:0] dd_next;
    reg         cmd_ok;

    always @* begin
        case (cmd_fmt_i)
            `FSDT_FMT_WI: sx = {{48{cmd_data_i[15]}}, cmd_data_i[15:0]};
            `FSDT_FMT_SI: sx = {{32{cmd_data_i[31]}}, cmd_data_i[31:0]};
            default:      sx = cmd_data_i[63:0];
        endcase
        mag       = sx[63] ? 64'h0 - sx : sx;
        ld_int_v  = int_to_tr(sx[63], mag);
        ld_real_v = (cmd_fmt_i == `FSDT_FMT_REG) ? sel_v
                                                  : real_to_tr(cmd_fmt_i, cmd_data_i);
        st_real_d = (cmd_fmt_i == `FSDT_FMT_TR) ? top_v
                  : {16'h0, st_real(cmd_fmt_i, top_v, rc_q, top_tag == `FSDT_TAG_SPECIAL)};
        isp       = int_split(top_v);
        irnd      = isp[65:2] + {63'h0, round_inc(rc_q, top_v[79], isp[2], isp[1], isp[0])};
        isgn      = top_v[79] ? 64'h0 - irnd : irnd;
        case (cmd_fmt_i)
            `FSDT_FMT_WI: st_int_d = {64'h0, isgn[15:0]};
            `FSDT_FMT_SI: st_int_d = {48'h0, isgn[31:0]};
            default:      st_int_d = {16'h0, isgn};
        endcase
        bcd_mag   = isp[65:2] + {63'h0, isp[1]};
        bld_next  = (bin_q << 3) + (bin_q << 1) + {60'h0, bcd_q[71:68]};
        dd_next   = {bcd_adj(bcd_q), bin_q} << 1;
        case (cmd_op_i)
            `FSDT_OP_LD_REAL:  cmd_ok = (cmd_fmt_i <= `FSDT_FMT_TR);
            `FSDT_OP_ST_REAL:  cmd_ok = (cmd_fmt_i <= `FSDT_FMT_LR);
            `FSDT_OP_ST_REALP: cmd_ok = (cmd_fmt_i <= `FSDT_FMT_TR);
            `FSDT_OP_XCHG:     cmd_ok = 1'b1;
            `FSDT_OP_LD_INT:   cmd_ok = (cmd_fmt_i >= `FSDT_FMT_WI && cmd_fmt_i <= `FSDT_FMT_LI);
            `FSDT_OP_ST_INT:   cmd_ok = (cmd_fmt_i == `FSDT_FMT_WI ||
                                         cmd_fmt_i == `FSDT_FMT_SI);
            `FSDT_OP_ST_INTP:  cmd_ok = (cmd_fmt_i >= `FSDT_FMT_WI &&
                                         cmd_fmt_i <= `FSDT_FMT_LI);
            `FSDT_OP_LD_BCD:   cmd_ok = 1'b1;
            `FSDT_OP_ST_BCDP:  cmd_ok = 1'b1;
            default:           cmd_ok = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // Stack moves
    // ------------------------------------------------------------------------
    task push;
        input [79:0] v;
        begin
            top_q                      <= p_dec;
            stk_q[p_dec]               <= v;
            tagw_q[{p_dec, 1'b0} +: 2] <= tag_of(v);
        end
    endtask

    task pop;
        begin
            tagw_q[{top_q, 1'b0} +: 2] <= `FSDT_TAG_EMPTY;
            top_q                      <= p_inc;
        end
    endtask

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tagw_q      <= `FSDT_TAGW_RST;
            top_q       <= `FSDT_TOP_RST;
            st_q        <= ST_IDLE;
            cnt_q       <= 7'h00;
            bin_q       <= 64'h0;
            bcd_q       <= 72'h0;
            sgn_q       <= 1'b0;
            ready_q     <= 1'b1;
            res_valid_q <= 1'b0;
            res_err_q   <= 1'b0;
            res_data_q  <= 80'h0;
        end else begin
            res_valid_q <= 1'b0;
            res_err_q   <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (cmd_valid_i) begin
                        res_valid_q <= 1'b1;
                        if (!cmd_ok) begin
                            res_err_q <= 1'b1;
                        end else begin
                            case (cmd_op_i)
                                `FSDT_OP_LD_REAL: begin
                                    push(ld_real_v);
                                end
                                `FSDT_OP_ST_REAL, `FSDT_OP_ST_REALP: begin
                                    if (cmd_fmt_i != `FSDT_FMT_REG) begin
                                        res_data_q <= st_real_d;
                                    end else if (reg_eff != 3'h0) begin
                                        stk_q[p_sel]               <= top_v;
                                        tagw_q[{p_sel, 1'b0} +: 2] <= top_tag;
                                    end
                                    // Register zero: no copy, pop alone
                                    if (cmd_op_i == `FSDT_OP_ST_REALP) begin
                                        pop;
                                    end
                                end
                                `FSDT_OP_XCHG: begin
                                    stk_q[top_q]               <= sel_v;
                                    stk_q[p_sel]               <= top_v;
                                    tagw_q[{top_q, 1'b0} +: 2] <= sel_tag;
                                    tagw_q[{p_sel, 1'b0} +: 2] <= top_tag;
                                end
                                `FSDT_OP_LD_INT: begin
                                    push(ld_int_v);
                                end
                                `FSDT_OP_ST_INT, `FSDT_OP_ST_INTP: begin
                                    res_data_q <= st_int_d;
                                    if (cmd_op_i == `FSDT_OP_ST_INTP) begin
                                        pop;
                                    end
                                end
                                `FSDT_OP_LD_BCD: begin
                                    res_valid_q <= 1'b0;
                                    ready_q     <= 1'b0;
                                    bcd_q       <= cmd_data_i[71:0];
                                    sgn_q       <= cmd_data_i[79];
                                    bin_q       <= 64'h0;
                                    cnt_q       <= 7'h00;
                                    st_q        <= ST_BLD;
                                end
                                `FSDT_OP_ST_BCDP: begin
                                    res_valid_q <= 1'b0;
                                    ready_q     <= 1'b0;
                                    bin_q       <= bcd_mag;
                                    bcd_q       <= 72'h0;
                                    sgn_q       <= top_v[79];
                                    cnt_q       <= 7'h00;
                                    st_q        <= ST_BST;
                                end
                                default: begin
                                    res_err_q <= 1'b1;
                                end
                            endcase
                        end
                    end
                end
                // Digit-serial: exact, one decimal digit a cycle
                ST_BLD: begin
                    bin_q <= bld_next;
                    bcd_q <= bcd_q << 4;
                    cnt_q <= cnt_q + 7'h01;
                    if (cnt_q == `FSDT_BLD_LAST) begin
                        push(int_to_tr(sgn_q, bld_next));
                        res_valid_q <= 1'b1;
                        ready_q     <= 1'b1;
                        st_q        <= ST_IDLE;
                    end
                end
                // Shift-add-three, one bit a cycle, to save area
                ST_BST: begin
                    {bcd_q, bin_q} <= dd_next;
                    cnt_q          <= cnt_q + 7'h01;
                    if (cnt_q == `FSDT_BST_LAST) begin
                        res_data_q  <= {sgn_q, 7'h00, dd_next[135:64]};
                        pop;
                        res_valid_q <= 1'b1;
                        ready_q     <= 1'b1;
                        st_q        <= ST_IDLE;
                    end
                end
                default: begin
                    st_q    <= ST_IDLE;
                    ready_q <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------------
    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            rc_q    <= `FSDT_RC_RST;
            rdata_q <= 32'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == `FSDT_OFF_CTRL) begin
                rc_q <= reg_wdata_i[`FSDT_CTRL_RC_LSB +: 2];
            end
            rdata_q <= 32'h0;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `FSDT_OFF_CTRL: rdata_q <= {30'h0, rc_q};
                    `FSDT_OFF_STAT: rdata_q <= {tagw_q, 13'h0, top_q};
                    default:        rdata_q <= 32'h0;
                endcase
            end
        end
    end

    assign cmd_ready_o = ready_q;
    assign res_valid_o = res_valid_q;
    assign res_err_o   = res_err_q;
    assign res_data_o  = res_data_q;
    assign reg_rdata_o = rdata_q;

endmodule // fsdt_core
